// ===== rtl/sadc_frame.sv
// Converter side of the three-wire serial frame: hold, track, shift, release
// How it works
// - Select falling edge after wake samples input, enters hold
// - 13th rising clock edge returns to track
// - 16th falling edge releases data line
// - About 1 us wake before valid result
// - Three zeros, ten bits MSB first, three zeros
// - Change on falling, host captures on rising
// - Select rising releases data line early
`timescale 1ns/1ps
module sadc_frame #(
    parameter int RES   = sadc_pkg::RES_BITS,
    parameter int DEPTH = 8
) (
    input  wire logic           clock,
    input  wire logic           rst_b,
    input  wire logic           selectPin_b,
    input  wire logic           shiftClkPin,
    output logic                serialOut,
    output logic                serialOutOe,
    input  wire logic [RES-1:0] sampleIn,
    input  wire logic           sampleValid,
    output logic                sampleReady,
    output logic                tracking,
    output logic                awake
);
    // Pin synchronisers: first stage read only by second
    logic [1:0] selSync_r;
    logic [1:0] sclkSync_r;
    logic       selPrev_r;
    logic       sclkPrev_r;

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            selSync_r  <= 2'h3;
            sclkSync_r <= 2'h0;
            selPrev_r  <= 1'h1;
            sclkPrev_r <= 1'h0;
        end else begin
            selSync_r  <= {selSync_r[0], selectPin_b};
            sclkSync_r <= {sclkSync_r[0], shiftClkPin};
            selPrev_r  <= selSync_r[1];
            sclkPrev_r <= sclkSync_r[1];
        end
    end

    wire selFall  = selPrev_r && !selSync_r[1];
    wire selRise  = !selPrev_r && selSync_r[1];
    wire sclkRise = !sclkPrev_r && sclkSync_r[1];
    wire sclkFall = sclkPrev_r && !sclkSync_r[1];

    // Results from the converter core queue here until a frame takes one
    logic [RES-1:0] fifoData;
    logic           fifoValid;
    logic           awake_r;
    wire            sampleReady_w;
    wire            inFrame;
    // No pop before wake or from an empty queue: that frame shifts zeros
    wire            takeSample = selFall && fifoValid && awake_r;

    sadc_fifo #(.WIDTH(RES), .DEPTH(DEPTH)) resultQueue (
        .clock    (clock),
        .rst_b    (rst_b),
        .inData   (sampleIn),
        .inValid  (sampleValid),
        .inReady  (sampleReady_w),
        .outData  (fifoData),
        .outValid (fifoValid),
        .outReady (takeSample)
    );

    sadc_pkg::sadc_state_t state_r;
    sadc_pkg::sadc_state_t state_nxt;
    logic [4:0]            riseCnt_r;
    logic [4:0]            fallCnt_r;
    logic [15:0]           shift_r;
    logic [7:0]            wakeCnt_r;
    sadc_pkg::sadc_pin_t   pin_r;
    logic                  tracking_r;
    logic                  sampleReady_r;

    assign inFrame = !selSync_r[1];
    // Frame word: leading zeros, result MSB first, trailing zeros
    wire [15:0] frameWord = {3'h0, (takeSample ? fifoData : {RES{1'b0}}), 3'h0};
    wire        lastFall  = sclkFall && (fallCnt_r + 5'h01 == sadc_pkg::RELEASE_EDGE);
    wire        trackHit  = sclkRise && (riseCnt_r + 5'h01 == sadc_pkg::TRACK_EDGE);

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            sadc_pkg::SADC_WAKE: begin
                if (awake_r) state_nxt = sadc_pkg::SADC_TRACK;
            end
            sadc_pkg::SADC_TRACK: begin
                if (selFall) state_nxt = sadc_pkg::SADC_HOLD;
            end
            sadc_pkg::SADC_HOLD: begin
                if (trackHit || selRise) state_nxt = sadc_pkg::SADC_TRACK;
            end
            default: state_nxt = sadc_pkg::SADC_WAKE;
        endcase
    end

    // Wake counter stands in for power-up from full power-down
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            wakeCnt_r <= sadc_pkg::WAKE_CNT_RST;
            awake_r   <= 1'b0;
        end else if (!awake_r) begin
            wakeCnt_r <= wakeCnt_r + 8'h01;
            awake_r   <= (wakeCnt_r == 8'(sadc_pkg::WAKE_CYCLES - 1));
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            state_r <= sadc_pkg::SADC_WAKE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Restart while select is high, so a cut frame leaves no stale count
    always_ff @(posedge clock) begin
        if (!rst_b || selFall || !inFrame) begin
            riseCnt_r <= sadc_pkg::EDGE_CNT_RST;
            fallCnt_r <= sadc_pkg::EDGE_CNT_RST;
        end else begin
            if (sclkRise && riseCnt_r != 5'h1f) riseCnt_r <= riseCnt_r + 5'h01;
            if (sclkFall && fallCnt_r != 5'h1f) fallCnt_r <= fallCnt_r + 5'h01;
        end
    end

    // Sample held at select fall; bits advance on falling clock edges
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            shift_r <= sadc_pkg::SHIFT_RST;
        end else if (selFall) begin
            shift_r <= frameWord;
        end else if (inFrame && sclkFall) begin
            shift_r <= {shift_r[14:0], 1'b0};
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            pin_r <= '0;
        end else if (selFall) begin
            pin_r.oe   <= 1'b1;
            pin_r.dout <= frameWord[15];
        end else if (selRise) begin
            pin_r <= '0;
        end else if (lastFall) begin
            pin_r <= '0;
        end else if (inFrame && sclkFall && pin_r.oe) begin
            pin_r.dout <= shift_r[14];
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            tracking_r    <= 1'b0;
            sampleReady_r <= 1'b0;
        end else begin
            tracking_r    <= (state_nxt == sadc_pkg::SADC_TRACK);
            sampleReady_r <= sampleReady_w;
        end
    end

    assign serialOut   = pin_r.dout;
    assign serialOutOe = pin_r.oe;
    assign tracking    = tracking_r;
    assign sampleReady = sampleReady_r;
    assign awake       = awake_r;
endmodule : sadc_frame

// Small valid/ready FIFO holding conversion results
module sadc_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 8
) (
    input  wire logic             clock,
    input  wire logic             rst_b,
    input  wire logic [WIDTH-1:0] inData,
    input  wire logic             inValid,
    output logic                  inReady,
    output logic      [WIDTH-1:0] outData,
    output logic                  outValid,
    input  wire logic             outReady
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wrPtr_r;
    logic [AW:0]      rdPtr_r;
    wire              full  = (wrPtr_r[AW] != rdPtr_r[AW])
                           && (wrPtr_r[AW-1:0] == rdPtr_r[AW-1:0]);
    wire              empty = (wrPtr_r == rdPtr_r);
    wire              push  = inValid && !full;
    wire              pop   = outReady && !empty;

    assign inReady  = !full;
    assign outValid = !empty;
    assign outData  = mem[rdPtr_r[AW-1:0]];

    always_ff @(posedge clock) begin
        if (push) begin
            mem[wrPtr_r[AW-1:0]] <= inData;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
        end else begin
            if (push) begin
                wrPtr_r <= wrPtr_r + 1'b1;
            end
            if (pop) begin
                rdPtr_r <= rdPtr_r + 1'b1;
            end
        end
    end
endmodule : sadc_fifo

// ===== pkg/sadc_pkg.sv
// Shared constants and types for the serial converter frame logic
package sadc_pkg;
    localparam int          RES_BITS       = 10;
    localparam int          FRAME_BITS     = 16;
    localparam int          LEAD_ZEROS     = 3;
    localparam logic [4:0]  TRACK_EDGE     = 5'h0d;  // 13th rising edge
    localparam logic [4:0]  RELEASE_EDGE   = 5'h10;  // 16th falling edge
    localparam logic [4:0]  EDGE_CNT_RST   = 5'h00;
    localparam int          CLK_PERIOD_PS  = 8000;
    localparam int          WAKE_TIME_NS   = 1000;
    localparam int          WAKE_CYCLES    = (WAKE_TIME_NS * 1000 + CLK_PERIOD_PS - 1)
                                             / CLK_PERIOD_PS;
    localparam logic [7:0]  WAKE_CNT_RST   = 8'h00;
    localparam logic [15:0] SHIFT_RST      = 16'h0000;

    typedef enum logic [2:0] {
        SADC_WAKE  = 3'b001,
        SADC_TRACK = 3'b010,
        SADC_HOLD  = 3'b100
    } sadc_state_t;

    // Serial data pin: value and output enable
    typedef struct packed {
        logic dout;
        logic oe;
    } sadc_pin_t;
endpackage : sadc_pkg

// ===== rtl/sadc_fifo.sv
// Empty: the result queue module sits beside the frame logic in one design file

// ===== verification/sadc_frame_checker.sv
// Pin-level assertions for the converter frame block
`timescale 1ns/1ps
module sadc_frame_checker (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic selectPin_b,
    input wire logic shiftClkPin,
    input wire logic serialOut,
    input wire logic serialOutOe,
    input wire logic tracking,
    input wire logic awake
);
    logic [2:0] selS_r, sckS_r;
    logic [4:0] riseCnt_r, fallCnt_r;
    logic [7:0] wakeCnt_r;
    // Own pin synchronisers, so edge counts lag the pins like the design's
    wire sckRise = sckS_r[1] & ~sckS_r[2];
    wire sckFall = sckS_r[2] & ~sckS_r[1];
    wire selLow  = ~selS_r[1];
    always_ff @(posedge clock) begin
        selS_r    <= {selS_r[1:0], selectPin_b};
        sckS_r    <= {sckS_r[1:0], shiftClkPin};
        riseCnt_r <= selLow ? riseCnt_r + 5'(sckRise) : 5'h00;
        fallCnt_r <= selLow ? fallCnt_r + 5'(sckFall) : 5'h00;
        wakeCnt_r <= !rst_b ? 8'h00 : wakeCnt_r + 8'(wakeCnt_r != 8'hff);
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    sequence holdStart;
        ##[1:5] (serialOutOe && !tracking);
    endsequence
    chk_hold_on_select: assert property (awake && $fell(selectPin_b) |-> holdStart)
        else $error("no hold after select fall");
    chk_lead_zeros: assert property (sckRise && riseCnt_r < 5'h03 && serialOutOe
        |-> !serialOut) else $error("leading bit not zero");
    chk_hold_midframe: assert property (sckRise && riseCnt_r inside {[1:11]} |-> !tracking)
        else $error("track before edge 13");
    chk_track_at_13: assert property (sckRise && riseCnt_r == 5'h0c |-> ##[1:4] tracking)
        else $error("no track at edge 13");
    chk_oe_stands: assert property (sckFall && fallCnt_r < 5'h0f && selLow && serialOutOe
        |=> serialOutOe[*3]) else $error("line released early");
    chk_release_16: assert property (sckFall && fallCnt_r == 5'h0f |-> ##[1:5] !serialOutOe)
        else $error("line held after edge 16");
    chk_release_select: assert property ($rose(selectPin_b) |-> ##[1:5] !serialOutOe)
        else $error("line held after select rise");
    chk_wake_time: assert property ($rose(awake) |-> wakeCnt_r inside {[8'h7b:8'h7f]})
        else $error("wake time wrong");
endmodule : sadc_frame_checker
bind sadc_frame sadc_frame_checker u_chk (.clock(clock), .rst_b(rst_b),
    .selectPin_b(selectPin_b), .shiftClkPin(shiftClkPin), .serialOut(serialOut),
    .serialOutOe(serialOutOe), .tracking(tracking), .awake(awake));

// ===== verification/sadc_host.sv
// Host model: frame select, shift clock, bit capture
`timescale 1ns/1ps
module sadc_host (
    output logic      selB,
    output logic      sclk,
    input  wire logic sdo,
    input  wire logic sdoOe
);
    logic lastBit = 1'b0;
    initial selB = 1'b1;
    initial sclk = 1'b0;
    // Clock stands low outside frames; a released line reads inverted
    task automatic frame(input int nRise, output logic [15:0] w);
        w = 16'h0000;
        selB = 1'b0;
        #80;
        for (int i = 0; i < nRise; i++) begin
            sclk = 1'b1;
            lastBit = sdoOe ? sdo : ~lastBit;
            w = {w[14:0], lastBit};
            #62.5 sclk = 1'b0;
            #62.5;
        end
        #400 selB = 1'b1;
        #100;
    endtask : frame
endmodule : sadc_host

// ===== verification/sadc_frame_tb_top.sv
// Self-checking bench for the converter frame block
`timescale 1ns/1ps
module sadc_frame_tb_top;
    logic        clock = 1'b0;
    logic        rst_b = 1'b0;
    logic [9:0]  sampleIn = 10'h000;
    logic        sampleValid = 1'b0;
    logic        selB, sclk, serialOut, serialOutOe, sampleReady, tracking, awake;
    logic [15:0] word;
    int          errTotal = 0;
    int          samplesChecked = 0;
    int          cycles = 0;
    always #4 clock = ~clock;
    sadc_frame dut (.clock(clock), .rst_b(rst_b), .selectPin_b(selB), .shiftClkPin(sclk),
        .serialOut(serialOut), .serialOutOe(serialOutOe), .sampleIn(sampleIn),
        .sampleValid(sampleValid), .sampleReady(sampleReady), .tracking(tracking),
        .awake(awake));
    sadc_host host (.selB(selB), .sclk(sclk), .sdo(serialOut), .sdoOe(serialOutOe));
    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string m);
        samplesChecked++;
        if (got !== exp) begin
            errTotal++;
            $display("unexpected at %0t: %s got %h", $time, m, got);
        end
    endtask : check
    function automatic logic [9:0] val(input int i);
        return 10'h2a5 ^ 10'(i * 10'h053);
    endfunction : val
    task automatic testWake;
        repeat (119) @(posedge clock);
        #1 check({15'h0, awake}, 16'h0000, "awake early");
        repeat (10) @(posedge clock);
        #1 check({15'h0, awake}, 16'h0001, "awake late");
        $display("wake test done");
    endtask : testWake
    task automatic testFrames;
        for (int i = 0; i < 9; i++) begin
            sampleIn <= val(i);
            sampleValid <= 1'b1;
            @(posedge clock);
        end
        sampleValid <= 1'b0;
        #1 check({15'h0, sampleReady}, 16'h0000, "fifo not full");
        // Ninth push refused, so the ninth frame finds the queue empty
        for (int i = 0; i < 9; i++) begin
            host.frame(16, word);
            check(word, i < 8 ? {3'b000, val(i), 3'b000} : 16'h0000, "frame");
            check({14'h0, tracking, serialOutOe}, 16'h0002, "idle pins");
        end
        $display("frame test done");
    endtask : testFrames
    task automatic testEarly;
        @(posedge clock);
        sampleIn <= 10'h3ff;
        sampleValid <= 1'b1;
        @(posedge clock);
        sampleValid <= 1'b0;
        repeat (4) @(posedge clock);
        host.frame(6, word);
        check(word, 16'h0007, "short frame");
        check({15'h0, serialOutOe}, 16'h0000, "line held");
        $display("early release test done");
    endtask : testEarly
    task automatic finishTest;
        $display("checks %0d mismatches %0d", samplesChecked, errTotal);
        if (errTotal == 0 && samplesChecked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : finishTest
    always @(posedge clock) begin
        cycles++;
        if (cycles == 10000) begin
            errTotal++;
            $display("unexpected at %0t: timeout", $time);
            finishTest();
        end
    end
    initial begin
        repeat (12) @(posedge clock);
        rst_b <= 1'b1;
        testWake();
        testFrames();
        testEarly();
        finishTest();
    end
endmodule : sadc_frame_tb_top
